// ### design/ctp_pkg.sv
// Constants, carriers and state layout for the counter/period channel
`default_nettype none
//------------------------------------------------------------------------------
// Summary of operation
// - Totalize counts up, wraps at 32 bits for either width
// - Clear-on-read latches old count, then zeroes
// - Saturate holds count at all ones
// - Width matters only when saturating
// - Latch at scan start, or mapped edge
// - Gate low freezes count in both modes
// - Own input increments, mapped input decrements
// - Mapped input may replace own increment source
// - Low-half read latches 32 bits, may clear
// - Asynchronous read only in counter mode
// - Read strobes selectable as mapped signals
// - Period spans like-polarity edge to edge
// - Scan repeats period result until next completes
// - Latching period clears counter, keeps edge
// - Acquisition start zeroes all counters
// - Tick is 1, 10, 100, 1000 clocks
// - Average field selects 1/10/100/1000 periods
// - Period results always saturate at width
// - Mapped input may replace measured period source
// - Only whole ticks are counted
// - Mapped from four inputs or four strobes
// - Scan start pulses once per scan
// - Scan result split into two halves
//------------------------------------------------------------------------------
package ctp_pkg;

	//------------------------------------------------------------------------------
	// Register map, byte addresses
	//------------------------------------------------------------------------------
	localparam int ADDR_W = 8;
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_ASYNC_LO = 8'h04;
	localparam logic [7:0] REG_ASYNC_HI = 8'h08;
	localparam logic [7:0] REG_SCAN = 8'h0C;
	localparam logic [7:0] REG_PERIOD = 8'h10;
	localparam logic [7:0] REG_COUNT = 8'h14;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	//------------------------------------------------------------------------------
	// Counting limits and timing counts (in sys_clk cycles)
	//------------------------------------------------------------------------------
	localparam logic [31:0] TOP_16 = 32'h0000_FFFF;
	localparam logic [31:0] TOP_32 = 32'hFFFF_FFFF;
	localparam logic [9:0] TICK_DIV_1 = 10'h001;
	localparam logic [9:0] TICK_DIV_10 = 10'h00A;
	localparam logic [9:0] TICK_DIV_100 = 10'h064;
	localparam logic [9:0] TICK_DIV_1000 = 10'h3E8;
	localparam logic [9:0] AVG_1 = 10'h001;
	localparam logic [9:0] AVG_10 = 10'h00A;
	localparam logic [9:0] AVG_100 = 10'h064;
	localparam logic [9:0] AVG_1000 = 10'h3E8;

	// Control register, bit 0 at the bottom of the list
	typedef struct packed {
		logic falling_edge;
		logic [2:0] map_select;
		logic [1:0] tick_select;
		logic [1:0] period_average_count;
		logic mapped_source_enable;
		logic mapped_decrement_enable;
		logic gate_enable;
		logic latch_source_select;
		logic width_select;
		logic saturate_select;
		logic clear_on_read_select;
		logic period_mode;
	} ctp_ctrl_s;
	localparam logic [15:0] CTRL_RESET = 16'h0000;

	// AXI4-Lite, master to slave
	typedef struct packed {
		logic awvalid;
		logic [ADDR_W-1:0] awaddr;
		logic wvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bready;
		logic arvalid;
		logic [ADDR_W-1:0] araddr;
		logic rready;
	} ctp_axi_req_s;

	// AXI4-Lite, slave to master
	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} ctp_axi_rsp_s;

	typedef enum logic [1:0] {
		AX_IDLE = 2'h0,
		AX_WRESP = 2'h1,
		AX_RRESP = 2'h2
	} ctp_axi_e;

	// Whole state of the channel
	typedef struct packed {
		ctp_ctrl_s ctrl;
		logic [31:0] count;
		logic [31:0] period_result;
		logic [31:0] scan_out;
		logic [31:0] async_latch;
		logic [9:0] prescale;
		logic [9:0] periods_seen;
		logic armed;
		logic own_q;
		logic map_q;
		logic strobe;
		ctp_axi_e ax;
		ctp_axi_rsp_s rsp;
	} ctp_state_s;
	localparam ctp_state_s STATE_RESET = '0;

endpackage : ctp_pkg
`default_nettype wire

// ### design/ctp_counter_channel.sv
// One counter channel: totalize and period modes behind an AXI4-Lite slave
`default_nettype none
module ctp_counter_channel
	import ctp_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic clk_en,
	input wire logic chan_in,
	input wire logic [3:0] mapped_inputs,
	input wire logic [3:0] read_strobes,
	input wire logic scan_start,
	input wire logic acq_start,
	input wire ctp_axi_req_s axi_req,
	output ctp_axi_rsp_s axi_rsp,
	output logic [31:0] scan_data,
	output logic async_read_strobe
);

	//------------------------------------------------------------------------------
	// State and decoded terms
	//------------------------------------------------------------------------------
	ctp_state_s r;
	ctp_state_s next_r;
	ctp_ctrl_s c;
	logic mapped;
	logic src;
	logic src_prev;
	logic src_rise;
	logic src_edge;
	logic map_rise;
	logic gate_ok;
	logic tick;
	logic inc;
	logic dec;
	logic latch_evt;
	logic rd_take;
	logic rd_async;
	logic wr_take;
	logic clr;
	logic [31:0] top;
	logic [31:0] base;
	logic [31:0] cnt_adv;
	logic [9:0] tdiv;
	logic [9:0] avg;
	logic [9:0] seen_next;
	logic [15:0] ctrl_w;

	assign c = r.ctrl;

	// Outputs come straight from the state flops
	assign axi_rsp = r.rsp;
	assign scan_data = r.scan_out;
	assign async_read_strobe = r.strobe;

	//------------------------------------------------------------------------------
	// Signal selection and edge detection
	//------------------------------------------------------------------------------
	// Mapped source: four inputs or four read strobes
	always_comb begin
		if (c.map_select[2]) begin
			mapped = read_strobes[c.map_select[1:0]];
		end else begin
			mapped = mapped_inputs[c.map_select[1:0]];
		end
	end

	// Edges compare the present input with last cycle's sample; a change of
	// map selection may show one false edge, software should reselect idle
	always_comb begin
		src = c.mapped_source_enable ? mapped : chan_in;
		src_prev = c.mapped_source_enable ? r.map_q : r.own_q;
		src_rise = src & ~src_prev;
		map_rise = mapped & ~r.map_q;
		if (c.falling_edge) begin
			src_edge = ~src & src_prev;
		end else begin
			src_edge = src_rise;
		end
		gate_ok = ~c.gate_enable | mapped;
		top = c.width_select ? TOP_32 : TOP_16;
	end

	// Tick divider and averaging length
	always_comb begin
		case (c.tick_select)
			2'h0: tdiv = TICK_DIV_1;
			2'h1: tdiv = TICK_DIV_10;
			2'h2: tdiv = TICK_DIV_100;
			default: tdiv = TICK_DIV_1000;
		endcase
		case (c.period_average_count)
			2'h0: avg = AVG_1;
			2'h1: avg = AVG_10;
			2'h2: avg = AVG_100;
			default: avg = AVG_1000;
		endcase
		tick = (r.prescale == (tdiv - 10'h001));
	end

	//------------------------------------------------------------------------------
	// Bus handshake terms
	//------------------------------------------------------------------------------
	// A read or write is taken at the edge where its ready is high
	always_comb begin
		wr_take = (r.ax == AX_WRESP) & r.rsp.awready;
		rd_take = (r.ax == AX_RRESP) & r.rsp.arready;
		// Period mode has no mapped latch, so the low half read is inert
		rd_async = rd_take & (axi_req.araddr == REG_ASYNC_LO) & ~c.period_mode;
		ctrl_w = r.ctrl;
		if (axi_req.wstrb[0]) begin
			ctrl_w[7:0] = axi_req.wdata[7:0];
		end
		if (axi_req.wstrb[1]) begin
			ctrl_w[15:8] = axi_req.wdata[15:8];
		end
	end

	//------------------------------------------------------------------------------
	// Counter mode datapath
	//------------------------------------------------------------------------------
	// Clearing reads the old value first, so an event in the same cycle
	// lands on the cleared count instead of being lost
	always_comb begin
		inc = gate_ok & src_rise;
		dec = gate_ok & c.mapped_decrement_enable & map_rise;
		if (c.latch_source_select) begin
			latch_evt = map_rise;
		end else begin
			latch_evt = scan_start;
		end
		clr = c.clear_on_read_select & (latch_evt | rd_async);
		base = clr ? 32'h0000_0000 : r.count;
		if (inc & ~dec) begin
			if (~c.saturate_select | (base < top)) begin
				base = base + 32'h0000_0001;
			end
		end else if (dec & ~inc) begin
			base = base - 32'h0000_0001;
		end
		// Both events together leave base unchanged
	end

	//------------------------------------------------------------------------------
	// Period mode datapath
	//------------------------------------------------------------------------------
	// Count advances only on a completed tick; the result saturates
	always_comb begin
		cnt_adv = r.count;
		if (gate_ok & tick & (r.count < top)) begin
			cnt_adv = r.count + 32'h0000_0001;
		end
		seen_next = r.periods_seen + 10'h001;
	end

	//------------------------------------------------------------------------------
	// Next-state logic
	//------------------------------------------------------------------------------
	always_comb begin
		next_r = r;
		next_r.own_q = chan_in;
		next_r.map_q = mapped;
		next_r.strobe = 1'b0;

		// Channel datapath
		if (c.period_mode) begin
			if (src_edge) begin
				next_r.prescale = 10'h000;
				if (!r.armed) begin
					// First edge opens the first measurement
					next_r.armed = 1'b1;
					next_r.count = 32'h0000_0000;
					next_r.periods_seen = 10'h000;
				end else if (seen_next == avg) begin
					next_r.period_result = cnt_adv;
					next_r.count = 32'h0000_0000;
					next_r.periods_seen = 10'h000;
				end else begin
					next_r.count = cnt_adv;
					next_r.periods_seen = seen_next;
				end
			end else if (gate_ok) begin
				next_r.count = cnt_adv;
				next_r.prescale = tick ? 10'h000 : r.prescale + 10'h001;
			end
			if (scan_start) begin
				next_r.scan_out = r.period_result;
			end
		end else begin
			next_r.count = base;
			next_r.armed = 1'b0;
			if (latch_evt) begin
				next_r.scan_out = r.count;
			end
			if (rd_async) begin
				next_r.async_latch = r.count;
				next_r.strobe = 1'b1;
			end
		end

		// Start of acquisition overrides all counting
		if (acq_start) begin
			next_r.count = 32'h0000_0000;
			next_r.scan_out = 32'h0000_0000;
			next_r.period_result = 32'h0000_0000;
			next_r.async_latch = 32'h0000_0000;
			next_r.prescale = 10'h000;
			next_r.periods_seen = 10'h000;
			next_r.armed = 1'b0;
		end

		// Bus slave; writes are taken only with address and data both present
		case (r.ax)
			AX_IDLE: begin
				if (axi_req.awvalid & axi_req.wvalid) begin
					next_r.rsp.awready = 1'b1;
					next_r.rsp.wready = 1'b1;
					next_r.ax = AX_WRESP;
				end else if (axi_req.arvalid) begin
					next_r.rsp.arready = 1'b1;
					next_r.ax = AX_RRESP;
				end
			end
			AX_WRESP: begin
				if (wr_take) begin
					next_r.rsp.awready = 1'b0;
					next_r.rsp.wready = 1'b0;
					next_r.rsp.bvalid = 1'b1;
					next_r.rsp.bresp = RESP_SLVERR;
					if (axi_req.awaddr == REG_CTRL) begin
						next_r.ctrl = ctp_ctrl_s'(ctrl_w);
						next_r.rsp.bresp = RESP_OKAY;
					end else if ((axi_req.awaddr == REG_ASYNC_LO) |
						(axi_req.awaddr == REG_ASYNC_HI) |
						(axi_req.awaddr == REG_SCAN) |
						(axi_req.awaddr == REG_PERIOD) |
						(axi_req.awaddr == REG_COUNT)) begin
						// Read-only registers ignore writes
						next_r.rsp.bresp = RESP_OKAY;
					end
				end else if (r.rsp.bvalid & axi_req.bready) begin
					next_r.rsp.bvalid = 1'b0;
					next_r.ax = AX_IDLE;
				end
			end
			AX_RRESP: begin
				if (rd_take) begin
					next_r.rsp.arready = 1'b0;
					next_r.rsp.rvalid = 1'b1;
					next_r.rsp.rresp = RESP_OKAY;
					case (axi_req.araddr)
						REG_CTRL: next_r.rsp.rdata = {16'h0000, r.ctrl};
						REG_ASYNC_LO: begin
							if (c.period_mode) begin
								next_r.rsp.rdata = {16'h0000, r.async_latch[15:0]};
							end else begin
								next_r.rsp.rdata = {16'h0000, r.count[15:0]};
							end
						end
						REG_ASYNC_HI: next_r.rsp.rdata = {16'h0000, r.async_latch[31:16]};
						REG_SCAN: next_r.rsp.rdata = r.scan_out;
						REG_PERIOD: next_r.rsp.rdata = r.period_result;
						REG_COUNT: next_r.rsp.rdata = r.count;
						default: begin
							next_r.rsp.rdata = 32'h0000_0000;
							next_r.rsp.rresp = RESP_SLVERR;
						end
					endcase
				end else if (r.rsp.rvalid & axi_req.rready) begin
					next_r.rsp.rvalid = 1'b0;
					next_r.ax = AX_IDLE;
				end
			end
			default: begin
				next_r.ax = AX_IDLE;
			end
		endcase
	end

	//------------------------------------------------------------------------------
	// State register
	//------------------------------------------------------------------------------
	// Clock enable low freezes every bit, bus included
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			r <= STATE_RESET;
		end else if (clk_en) begin
			r <= next_r;
		end
	end

endmodule : ctp_counter_channel
`default_nettype wire

// ### verif/ctp_checker.sv
// Port assertions for the counter channel
`default_nettype none
module ctp_checker
	import ctp_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic [3:0] mapped_inputs,
	input wire logic [3:0] read_strobes,
	input wire logic scan_start,
	input wire logic acq_start,
	input wire ctp_axi_req_s axi_req,
	input wire ctp_axi_rsp_s axi_rsp,
	input wire logic [31:0] scan_data,
	input wire logic async_read_strobe
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge sys_clk);
	endclocking
	default disable iff (!rst_b);
	// Answers follow the readies by one cycle; the bench drops clk_en only while the bus is idle
	AST_WR_ANS: assert property (axi_rsp.awready |-> axi_rsp.wready ##1 axi_rsp.bvalid)
		else $error("late write answer");
	AST_RD_ANS: assert property (axi_rsp.arready |=> axi_rsp.rvalid && !axi_rsp.arready)
		else $error("late read answer");
	AST_R_DROP: assert property (axi_rsp.rvalid && axi_req.rready |=> !axi_rsp.rvalid)
		else $error("read answer held");
	AST_ERR_ZERO: assert property (axi_rsp.rvalid && axi_rsp.rresp == RESP_SLVERR
		|-> axi_rsp.rdata == '0)
		else $error("refused read has data");
	AST_STB_ONE: assert property (async_read_strobe |=> !async_read_strobe)
		else $error("read strobe too long");
	AST_STB_CAUSE: assert property ($rose(async_read_strobe) |->
		axi_rsp.rvalid && $past(axi_rsp.arready))
		else $error("read strobe without read");
	// A result may only move after a latch cause or an acquisition start
	AST_SCAN_HOLD: assert property ($changed(scan_data) |->
		$past(scan_start || acq_start) || $past(mapped_inputs) != $past(mapped_inputs, 2)
		|| $past(read_strobes) != $past(read_strobes, 2))
		else $error("result moved unprompted");
	AST_ACQ_ZERO: assert property (acq_start && !scan_start |=> scan_data == '0)
		else $error("result not zeroed");
	cover property (axi_rsp.bvalid && axi_req.bready);
	cover property (async_read_strobe);
	cover property (scan_start ##2 scan_data != '0);
endmodule : ctp_checker
bind ctp_counter_channel ctp_checker u_chk (.sys_clk, .rst_b, .mapped_inputs, .read_strobes,
	.scan_start, .acq_start, .axi_req, .axi_rsp, .scan_data, .async_read_strobe);
`default_nettype wire

// ### verif/ctp_scan_seq.sv
// Scan sequencer model: pulses scan start, gathers both result slots
`default_nettype none
module ctp_scan_seq (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic req,
	input wire logic [31:0] scan_data,
	output logic scan_start,
	output logic [31:0] got,
	output logic done
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] sr;
	// Low slot first, high slot one sample later, as the stream carries them
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			{sr, scan_start, got, done} <= '0;
		end else begin
			scan_start <= req;
			sr <= {sr[0], scan_start};
			if (sr[0]) got[15:0] <= scan_data[15:0];
			if (sr[1]) got[31:16] <= scan_data[31:16];
			done <= sr[1];
		end
	end
endmodule : ctp_scan_seq
`default_nettype wire

// ### verif/tb_counter_totalize_period_channel.sv
// Self-checking bench for the counter/period channel
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin miscompares++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module tb_counter_totalize_period_channel
	import ctp_pkg::*;
();
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk = 0, rst_b = 0, chan_in = 0, sreq = 0, acq = 0, ce = 1;
	logic scan_start, done, strobe;
	logic [3:0] mi = '0;
	logic [31:0] scan_data, got, d;
	logic [31:0] seed = 32'h5f9b_1621;
	logic [1:0] r;
	ctp_axi_req_s rq = '0;
	ctp_axi_rsp_s rs;
	int miscompares = 0;
	int samples_checked = 0;
	int cyc = 0;
	int n, m;
	int dv[4] = '{1, 10, 100, 1000};
	// Period cases: tick code, average code, input period, source (-1 own input)
	int pc[7][4] = '{'{0, 0, 12, -1}, '{1, 0, 40, -1}, '{2, 0, 200, -1}, '{3, 0, 2000, -1},
		'{0, 1, 6, 3}, '{0, 2, 4, -1}, '{0, 3, 4, -1}};
	ctp_counter_channel dut (.sys_clk, .rst_b, .clk_en(ce), .chan_in, .mapped_inputs(mi),
		.read_strobes({3'b000, strobe}), .scan_start, .acq_start(acq), .axi_req(rq),
		.axi_rsp(rs), .scan_data, .async_read_strobe(strobe));
	ctp_scan_seq u_seq (.sys_clk, .rst_b, .req(sreq), .scan_data, .scan_start, .got, .done);
	// Clock, 4 ns period
	initial begin
		forever #2 sys_clk = ~sys_clk;
	end
	// Hang guard, far above the longest period case
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			miscompares++;
			stop_test();
		end
	end
	function automatic logic [31:0] xs(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		return x ^ (x << 5);
	endfunction : xs
	task automatic stop_test();
		$display("TB: checked %0d, failed %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : stop_test
	task automatic tick(input int k);
		repeat (k) @(posedge sys_clk);
	endtask : tick
	// Bus master: each channel held until its own ready, answers waited for
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		bit ga = 0;
		bit gw = 0;
		@(posedge sys_clk);
		rq <= {1'b1, a, 1'b1, v, 4'hF, 1'b1, 10'h000};
		while (!(ga && gw)) begin
			@(posedge sys_clk);
			ga |= rs.awready;
			gw |= rs.wready;
			rq.awvalid <= !ga;
			rq.wvalid <= !gw;
		end
		do @(posedge sys_clk); while (!rs.bvalid);
		rq.bready <= 0;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] e);
		@(posedge sys_clk);
		rq <= {47'h0, 1'b1, a, 1'b1};
		do @(posedge sys_clk); while (!rs.arready);
		rq.arvalid <= 0;
		do @(posedge sys_clk); while (!rs.rvalid);
		rq.rready <= 0;
		v = rs.rdata;
		e = rs.rresp;
	endtask : rd
	// Level on own input (w < 0) or a mapped input, held h cycles
	task automatic drv(input int w, input logic v, input int h);
		@(posedge sys_clk);
		if (w < 0) chan_in <= v;
		else mi[w] <= v;
		tick(h - 1);
	endtask : drv
	// Settle time lets the last edge reach the count before a latch
	task automatic pulse(input int k, input int w, input int h);
		repeat (k) begin
			drv(w, 1, h);
			drv(w, 0, h);
		end
		tick(3);
	endtask : pulse
	task automatic zero();
		@(posedge sys_clk);
		acq <= 1;
		@(posedge sys_clk);
		acq <= 0;
		tick(2);
	endtask : zero
	task automatic scan(input logic [31:0] e);
		@(posedge sys_clk);
		sreq <= 1;
		@(posedge sys_clk);
		sreq <= 0;
		do @(posedge sys_clk); while (!done);
		`CHK(got, e)
	endtask : scan
	// Main sequence
	initial begin
		tick(5);
		rst_b <= 1;
		rd(REG_CTRL, d, r);
		`CHK(d, 32'h0000_0000)
		rd(8'h40, d, r);
		`CHK(r, RESP_SLVERR)
		for (int i = 0; i < 3; i++) begin
			seed = xs(seed);
			n = seed[4:0] + 1;
			zero();
			pulse(n, -1, 1);
			scan(n);
			scan(n);
		end
		wr(REG_CTRL, 32'h0000_0002);
		zero();
		pulse(n, -1, 1);
		scan(n);
		scan(0);
		pulse(5, -1, 1);
		rd(REG_ASYNC_LO, d, r);
		`CHK(d, 32'h0000_0005)
		rd(REG_ASYNC_HI, d, r);
		`CHK(d, 32'h0000_0000)
		rd(REG_COUNT, d, r);
		`CHK(d, 32'h0000_0000)
		$display("TB: totalize and clear done");
		wr(REG_CTRL, 32'h0000_0040);
		zero();
		pulse(1, 0, 1);
		scan(32'hFFFF_FFFF);
		pulse(1, -1, 1);
		scan(0);
		pulse(1, 0, 1);
		// Both halves of a nonzero count come back through the async pair
		rd(REG_ASYNC_LO, d, r);
		`CHK(d, 32'h0000_FFFF)
		rd(REG_ASYNC_HI, d, r);
		`CHK(d, 32'h0000_FFFF)
		wr(REG_CTRL, 32'h0000_000C);
		pulse(2, -1, 1);
		scan(32'hFFFF_FFFF);
		wr(REG_CTRL, 32'h0000_0008);
		pulse(1, -1, 1);
		scan(0);
		// Clock enable low: pulses in that time must leave no trace
		@(posedge sys_clk);
		ce <= 0;
		pulse(3, -1, 1);
		ce <= 1;
		scan(0);
		$display("TB: wrap and saturate done");
		wr(REG_CTRL, 32'h0000_0020);
		zero();
		pulse(4, -1, 1);
		scan(0);
		drv(0, 1, 1);
		pulse(4, -1, 1);
		drv(0, 0, 1);
		scan(4);
		wr(REG_CTRL, 32'h0000_1080);
		zero();
		pulse(4, -1, 1);
		pulse(3, 1, 1);
		scan(3);
		wr(REG_CTRL, 32'h0000_4010);
		zero();
		pulse(n, -1, 1);
		rd(REG_ASYNC_LO, d, r);
		tick(2);
		rd(REG_SCAN, d, r);
		`CHK(d, 32'(n))
		$display("TB: mapped options done");
		foreach (pc[i]) begin
			m = pc[i][3] < 0 ? 0 : 32'h0000_3080;
			wr(REG_CTRL, 32'(1 + (pc[i][1] << 8) + (pc[i][0] << 10) + m));
			zero();
			pulse(dv[pc[i][1]] + 1, pc[i][3], pc[i][2] / 2);
			m = dv[pc[i][1]] * pc[i][2] / dv[pc[i][0]];
			scan(m);
			scan(m);
			rd(REG_PERIOD, d, r);
			`CHK(d, 32'(m))
			// Low-half read in period mode must not expose the live count
			rd(REG_ASYNC_LO, d, r);
			`CHK(d, 32'h0000_0000)
		end
		// Falling to falling, tick 1, one period of 10 cycles
		wr(REG_CTRL, 32'h0000_8001);
		zero();
		pulse(2, -1, 5);
		scan(10);
		$display("TB: period done");
		stop_test();
	end
endmodule : tb_counter_totalize_period_channel
`default_nettype wire
